// [hw/pcf_pkg.sv]
// Purpose: Shared constants and types of the port pin function block
// Assumes: Byte-wide register port, printed byte offsets used as is
// Notes:   Port index order C F G J K L M N P R T U V W X Z
package pcf_pkg;

  // ****************************************************************
  // Port indices and sizes
  // ****************************************************************
  localparam int NUM_PORTS = 16;
  localparam int NUM_DRV   = 12;
  localparam int IDX_C     = 0;
  localparam int IDX_F     = 1;
  localparam int IDX_G     = 2;
  localparam int IDX_N     = 7;
  localparam int IDX_P     = 8;
  localparam int IDX_U     = 11;
  localparam int IDX_V     = 12;
  localparam int IDX_X     = 14;
  localparam int DRV_C     = 10;
  localparam int DRV_F     = 11;

  typedef logic [NUM_PORTS-1:0][7:0] pcf_port_bytes_t;
  typedef logic [NUM_DRV-1:0][7:0]   pcf_drv_bytes_t;

  // Pin drive pair, also used for peripheral requests
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } pcf_pin_t;

  typedef pcf_pin_t [NUM_PORTS-1:0] pcf_pins_t;

  // ****************************************************************
  // Register offsets, listed from port Z down to port C
  // ****************************************************************
  localparam pcf_port_bytes_t DATA_OFS = {
    8'h68, 8'hB0, 8'hAC, 8'hA8, 8'hA4, 8'hA0, 8'h64, 8'h60,
    8'h5C, 8'h58, 8'h54, 8'h50, 8'h4C, 8'h40, 8'h3C, 8'h30};
  localparam pcf_port_bytes_t DIR_OFS = {
    8'h6A, 8'hB2, 8'hAE, 8'hAA, 8'hA6, 8'hA2, 8'h66, 8'h62,
    8'h5E, 8'h00, 8'h00, 8'h00, 8'h4E, 8'h00, 8'h3E, 8'h32};
  localparam pcf_port_bytes_t FUNC_OFS = {
    8'h00, 8'hB3, 8'hAF, 8'hAB, 8'hA7, 8'hA3, 8'h67, 8'h63,
    8'h5F, 8'h5B, 8'h57, 8'h53, 8'h4F, 8'h43, 8'h3F, 8'h33};
  localparam pcf_drv_bytes_t DRV_OFS = {
    8'h8F, 8'h8C, 8'h8A, 8'h89, 8'h88, 8'h87, 8'h86, 8'h85,
    8'h84, 8'h83, 8'h82, 8'h81};
  localparam logic [7:0] KEY_EN_OFS = 8'h2B;
  localparam logic [7:0] P9_TYPE_OFS = 8'h25;

  // ****************************************************************
  // Implemented bits; a zero mask means no such register
  // ****************************************************************
  localparam pcf_port_bytes_t DIR_MASK = {
    8'hFF, 8'hA0, 8'hFF, 8'hC7, 8'hFF, 8'hFF, 8'h0F, 8'h3E,
    8'hFF, 8'h00, 8'h00, 8'h00, 8'h60, 8'h00, 8'h3F, 8'hFF};
  localparam pcf_port_bytes_t FUNC_MASK = {
    8'h00, 8'h30, 8'h00, 8'hC1, 8'hFF, 8'hFF, 8'h0F, 8'hFE,
    8'hFF, 8'h86, 8'hFF, 8'hFF, 8'hFF, 8'h08, 8'hBF, 8'hFF};
  localparam pcf_drv_bytes_t DRV_MASK = {
    8'hBF, 8'hFF, 8'hFF, 8'hC7, 8'hFF, 8'h7F, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] P9_TYPE_MASK = 8'h01;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] KEY_EN_RST = 8'h00;
  localparam logic [7:0] P9_TYPE_RST = 8'h00;
  localparam pcf_port_bytes_t FUNC_RST = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  localparam pcf_drv_bytes_t DRV_RST = DRV_MASK;

  // Bit positions with special meaning
  localparam int BIT_C_KEY_SCAN = 7;
  localparam int BIT_G_TRIGGER  = 3;
  localparam int BIT_U_LCD21    = 5;
  localparam int BIT_V_SER_CLK  = 0;
  localparam int BIT_X_CLK_OUT  = 4;
  localparam logic [7:0] P_DIR_GATED = 8'h38;

endpackage

// [hw/pcf_pin_cell.sv]
// Purpose: One 8-pin port output stage with peripheral override
// Assumes: Inputs synchronous to clk_sys_i
// Notes:   All outputs registered; open drain only pulls low
`timescale 1ns/1ns
module pcf_pin_cell
  import pcf_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic [7:0] sel_i,
  input  wire logic [7:0] dir_i,
  input  wire logic [7:0] latch_i,
  input  wire logic [7:0] od_i,
  input  wire logic [7:0] hold_off_i,
  input  wire pcf_pin_t   periph_i,
  input  wire logic [7:0] pin_i,
  output logic      [7:0] pin_o,
  output logic      [7:0] pin_oe_o,
  output logic      [7:0] periph_in_o
);

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] in;
  } pcf_cell_st_t;

  pcf_cell_st_t s_q;
  pcf_cell_st_t s_d;

  // ****************************************************************
  // Pin steering
  // ****************************************************************
  always_comb
  begin
    logic [7:0] val;
    logic [7:0] en;
    val = (sel_i & periph_i.o) | (~sel_i & latch_i);
    en  = (sel_i & periph_i.oe) | (~sel_i & dir_i);
    en  = en & ~(od_i & val);
    s_d.o  = val & ~od_i;
    s_d.oe = en & ~hold_off_i;
    s_d.in = pin_i & sel_i;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign pin_o       = s_q.o;
  assign pin_oe_o    = s_q.oe;
  assign periph_in_o = s_q.in;

endmodule

// [hw/pcf_top.sv]
// Purpose: Port direction, function select, output type and standby
//          drive registers steering the general purpose port pins
// Assumes: Plain register port, read data one cycle after read strobe
// Notes:   Direction and function registers read back as zero
`timescale 1ns/1ns
module pcf_top
  import pcf_pkg::*;
(
  input  wire logic                        clk_sys_i,
  input  wire logic                        resetn_i,
  input  wire logic [7:0]                  addr_i,
  input  wire logic [7:0]                  wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [7:0]                  rdata_o,
  input  wire logic                        standby_i,
  input  wire logic                        sys_clk_out_i,
  input  wire logic                        lcd_div_i,
  input  wire pcf_pins_t                   periph_i,
  input  wire logic [NUM_PORTS-1:0][7:0]   pin_i,
  output logic      [NUM_PORTS-1:0][7:0]   pin_o,
  output logic      [NUM_PORTS-1:0][7:0]   pin_oe_o,
  output logic      [NUM_PORTS-1:0][7:0]   periph_in_o,
  output logic      [7:0]                  key_in_enable_o,
  output logic                             serial0_transmit_od_o,
  output logic      [NUM_DRV-1:0][7:0]     standby_drive_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    pcf_port_bytes_t dir;
    pcf_port_bytes_t func;
    pcf_port_bytes_t latch;
    pcf_drv_bytes_t  drv;
    logic [7:0]      key_en;
    logic [7:0]      p9_type;
    logic [7:0]      rdata;
  } pcf_state_t;

  pcf_state_t s_q;
  pcf_state_t s_d;

  pcf_port_bytes_t sel;
  pcf_port_bytes_t od;
  pcf_port_bytes_t hold_off;
  pcf_pins_t       per;

  // ****************************************************************
  // Register port: writes and reads
  // ****************************************************************
  // Write-only registers read back as zero, so a read-modify-write of a
  // write-only register would clear settings; software must avoid it
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (wr_i && addr_i == DATA_OFS[p])
        s_d.latch[p] = wdata_i;
      if (wr_i && DIR_MASK[p] != 8'h00 && addr_i == DIR_OFS[p])
        s_d.dir[p] = wdata_i & DIR_MASK[p];
      if (wr_i && FUNC_MASK[p] != 8'h00 && addr_i == FUNC_OFS[p])
        s_d.func[p] = wdata_i & FUNC_MASK[p];
      if (rd_i && addr_i == DATA_OFS[p])
        s_d.rdata = pin_i[p];
    end
    for (int d = 0; d < NUM_DRV; d++)
    begin
      if (wr_i && addr_i == DRV_OFS[d])
        s_d.drv[d] = wdata_i & DRV_MASK[d];
      if (rd_i && addr_i == DRV_OFS[d])
        s_d.rdata = s_q.drv[d];
    end
    if (wr_i && addr_i == KEY_EN_OFS)
      s_d.key_en = wdata_i;
    if (wr_i && addr_i == P9_TYPE_OFS)
      s_d.p9_type = wdata_i & P9_TYPE_MASK;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_q.dir     <= {NUM_PORTS{DIR_RST}};
      s_q.func    <= FUNC_RST;
      s_q.latch   <= {NUM_PORTS{LATCH_RST}};
      s_q.drv     <= DRV_RST;
      s_q.key_en  <= KEY_EN_RST;
      s_q.p9_type <= P9_TYPE_RST;
      s_q.rdata   <= 8'h00;
    end
    else
      s_q <= s_d;
  end

  // ****************************************************************
  // Per-port steering
  // ****************************************************************
  always_comb
  begin
    sel      = s_q.func;
    per      = periph_i;
    od       = '0;
    hold_off = '0;
    // Port N register picks output type, not a peripheral
    sel[IDX_N] = 8'h00;
    od[IDX_N]  = s_q.func[IDX_N];
    od[IDX_C][BIT_C_KEY_SCAN] = s_q.func[IDX_C][BIT_C_KEY_SCAN];
    sel[IDX_U][BIT_U_LCD21] = s_q.func[IDX_U][BIT_U_LCD21]
                            & s_q.dir[IDX_U][BIT_U_LCD21];
    sel[IDX_V][BIT_V_SER_CLK] = s_q.func[IDX_V][BIT_V_SER_CLK]
                              & s_q.dir[IDX_V][BIT_V_SER_CLK];
    // Direction 0 turns timer pins into interrupt inputs
    per[IDX_P].oe = periph_i[IDX_P].oe
                  & (s_q.dir[IDX_P] | ~P_DIR_GATED);
    per[IDX_G].oe[BIT_G_TRIGGER] = 1'b0;
    per[IDX_X].o[BIT_X_CLK_OUT] = s_q.latch[IDX_X][BIT_X_CLK_OUT]
                                ? lcd_div_i : sys_clk_out_i;
    per[IDX_F].oe[7] = 1'b1;
    if (standby_i)
    begin
      hold_off[IDX_C] = ~s_q.drv[DRV_C];
      hold_off[IDX_F] = ~s_q.drv[DRV_F];
    end
  end

  // ****************************************************************
  // Pin stages
  // ****************************************************************
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    pcf_pin_cell u_cell (
      .clk_sys_i   (clk_sys_i),
      .resetn_i    (resetn_i),
      .sel_i       (sel[p]),
      .dir_i       (s_q.dir[p]),
      .latch_i     (s_q.latch[p]),
      .od_i        (od[p]),
      .hold_off_i  (hold_off[p]),
      .periph_i    (per[p]),
      .pin_i       (pin_i[p]),
      .pin_o       (pin_o[p]),
      .pin_oe_o    (pin_oe_o[p]),
      .periph_in_o (periph_in_o[p])
    );
  end

  assign rdata_o               = s_q.rdata;
  assign key_in_enable_o       = s_q.key_en;
  assign serial0_transmit_od_o = s_q.p9_type[0];
  assign standby_drive_o       = s_q.drv;

endmodule

// [testbench/pcf_top_chk.sv]
// Purpose: Port-level checks of the pin configuration block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Keeps its own copy of the port N output type
`timescale 1ns/1ns
module pcf_top_chk
  import pcf_pkg::*;
(
  input wire logic                      clk_sys_i,
  input wire logic                      resetn_i,
  input wire logic [7:0]                addr_i,
  input wire logic [7:0]                wdata_i,
  input wire logic                      wr_i,
  input wire logic                      rd_i,
  input wire logic [7:0]                rdata_o,
  input wire logic [NUM_PORTS-1:0][7:0] pin_i,
  input wire logic [NUM_PORTS-1:0][7:0] pin_o,
  input wire logic [NUM_PORTS-1:0][7:0] pin_oe_o,
  input wire logic [NUM_DRV-1:0][7:0]   standby_drive_o
);
  // ************************************************************
  // Properties
  // ************************************************************
  logic [7:0] n_type_q;
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      n_type_q <= 8'h00;
    else if (wr_i && addr_i == 8'h5F)
      n_type_q <= wdata_i;
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_rel;
    $rose(resetn_i);
  endsequence
  sequence s_rd(a);
    rd_i && addr_i == a;
  endsequence
  property p_rst_dir;
    s_rel |-> ##1 pin_oe_o[IDX_C] == 8'h00;
  endproperty
  a_rst_dir: assert property (p_rst_dir)
    else $error("port C not input after reset");
  property p_rst_sdram;
    s_rel |-> ##1 pin_oe_o[IDX_F][7];
  endproperty
  a_rst_sdram: assert property (p_rst_sdram)
    else $error("port F bit 7 not driven after reset");
  property p_rst_drv;
    s_rel |-> standby_drive_o[DRV_F] == 8'hBF;
  endproperty
  a_rst_drv: assert property (p_rst_drv)
    else $error("drive register reset value wrong");
  property p_wo_read;
    rd_i && (addr_i == 8'h32 || addr_i == 8'h33) |=> rdata_o == 8'h00;
  endproperty
  a_wo_read: assert property (p_wo_read)
    else $error("write-only register read back");
  property p_unmapped;
    s_rd(8'hFF) |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_drv_read;
    s_rd(8'h81) |=> rdata_o == $past(standby_drive_o[0]);
  endproperty
  a_drv_read: assert property (p_drv_read)
    else $error("drive register read wrong");
  property p_pin_read;
    s_rd(8'h30) |=> rdata_o == $past(pin_i[IDX_C]);
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("data read not pin level");
  // Open drain never drives a high level
  property p_n_od;
    (pin_o[IDX_N] & $past(n_type_q)) == 8'h00;
  endproperty
  a_n_od: assert property (p_n_od)
    else $error("open-drain pin driven high");
endmodule

bind pcf_top pcf_top_chk u_chk (.clk_sys_i, .resetn_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_i, .pin_o, .pin_oe_o,
  .standby_drive_o);

// [testbench/tb_top.sv]
// Purpose: Self-checking bench of the pin configuration block
// Assumes: Register strobes one cycle, read data next cycle
// Notes:   Pins checked one edge after the write is taken
`timescale 1ns/1ns
module tb_top
  import pcf_pkg::*;
;
  localparam logic [4:0][7:0] WO_ADDR = {8'h32, 8'h33, 8'h2B, 8'h5F, 8'hFF};
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic standby_i = 1'b0, sys_clk_out_i = 1'b0, lcd_div_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00;
  logic [7:0] rdata_o, key_in_enable_o, r, v, t;
  logic serial0_transmit_od_o;
  pcf_pins_t periph_i = '0;
  logic [NUM_PORTS-1:0][7:0] pin_i = '0, pin_o, pin_oe_o, periph_in_o;
  logic [NUM_DRV-1:0][7:0] standby_drive_o;
  logic [7:0] exp_q[$];
  int error_cnt = 0, n_tests = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  pcf_top uut (.clk_sys_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .standby_i, .sys_clk_out_i, .lcd_div_i, .periph_i, .pin_i,
    .pin_o, .pin_oe_o, .periph_in_o, .key_in_enable_o,
    .serial0_transmit_od_o, .standby_drive_o);

  // ************************************************************
  // Bus tasks and checks
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic settle();
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("TB: %0d checks, %0d errors", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    $display("ERROR %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial
  begin
    void'($urandom(59));
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    settle();
    chk(pin_oe_o[IDX_F] & 8'h80, 8'h80);
    chk(pin_oe_o[IDX_C], 8'h00);
    chk(key_in_enable_o, 8'h00);
    wr(8'hFF, 8'h5A);
    for (int i = 0; i < 5; i++)
    begin
      rd(WO_ADDR[i], r);
      chk(r, 8'h00);
    end
    $display("test done: reset and read-back");
    v = 8'($urandom);
    t = 8'($urandom);
    wr(8'h32, v);
    wr(8'h30, t);
    settle();
    chk(pin_oe_o[IDX_C], v);
    chk(pin_o[IDX_C] & v, t & v);
    wr(8'h8C, 8'h00);
    standby_i <= 1'b1;
    settle();
    chk(pin_oe_o[IDX_C], 8'h00);
    standby_i <= 1'b0;
    wr(8'h5E, 8'hFF);
    wr(8'h5C, v);
    wr(8'h5F, t);
    settle();
    chk(pin_o[IDX_N], v & ~t);
    chk(pin_oe_o[IDX_N], ~(v & t));
    periph_i[4] <= {t, v};
    wr(8'h53, 8'hFF);
    settle();
    chk(pin_o[4], t);
    chk(pin_oe_o[4], v);
    wr(8'h2B, v);
    settle();
    chk(key_in_enable_o, v);
    periph_i[IDX_U] <= 16'hFFFF;
    periph_i[IDX_P] <= 16'hFFFF;
    wr(8'hA7, 8'hFF);
    wr(8'hA6, 8'h00);
    wr(8'h63, 8'hFF);
    settle();
    chk(pin_oe_o[IDX_U], 8'hDF);
    chk(pin_o[IDX_U], 8'hDF);
    chk(pin_oe_o[IDX_P], 8'hC6);
    $display("test done: pin steering");
    wr(8'h25, 8'hFF);
    settle();
    chk({7'h00, serial0_transmit_od_o}, 8'h01);
    wr(8'h25, 8'hFE);
    settle();
    chk({7'h00, serial0_transmit_od_o}, 8'h00);
    sys_clk_out_i <= 1'b1;
    wr(8'hB3, 8'h10);
    wr(8'hB0, 8'h00);
    settle();
    chk({7'h00, pin_o[IDX_X][4]}, 8'h01);
    sys_clk_out_i <= 1'b0;
    lcd_div_i <= 1'b1;
    wr(8'hB0, 8'h10);
    settle();
    chk({7'h00, pin_o[IDX_X][4]}, 8'h01);
    $display("test done: clock and serial pins");
    for (int i = 0; i < NUM_PORTS; i++)
      pin_i[i] <= 8'($urandom);
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      rd(DATA_OFS[i], r);
      chk(r, pin_i[i]);
    end
    chk(periph_in_o[4], pin_i[4]);
    chk(periph_in_o[IDX_C], 8'h00);
    for (int i = 0; i < NUM_DRV; i++)
    begin
      v = 8'($urandom);
      wr(DRV_OFS[i], v);
      exp_q.push_back(v & DRV_MASK[i]);
    end
    for (int i = 0; i < NUM_DRV; i++)
    begin
      rd(DRV_OFS[i], r);
      chk(r, exp_q.pop_front());
    end
    $display("test done: data and drive registers");
    report_and_stop();
  end
endmodule
